// ---- design/io_ports_params.svh ----
// Purpose: offsets, field positions and reset values of the i/o ports
// Assumes: data memory addresses are 8 bits wide
// Notes:   included by bare name from every design file except the package
`ifndef IO_PORTS_PARAMS_SVH
`define IO_PORTS_PARAMS_SVH

// data memory locations of the port registers
`define OFS_PORT_A_LATCH     8'h12
`define OFS_PORT_A_DIRECTION 8'h13
`define OFS_PORT_B_LATCH     8'h14
`define OFS_PORT_B_DIRECTION 8'h15
`define OFS_PORT_C_LATCH     8'h16
`define OFS_PORT_C_DIRECTION 8'h17

// reset values: all lines input, latches cleared
`define RST_DIRECTION        8'hff
`define RST_LATCH            8'h00
`define RST_NONE             8'h00

// shared line positions on the first and third port
`define LINE_FREQ_OUT        3'h3
`define LINE_TIMER_ZERO      3'h4
`define LINE_TIMER_ONE       3'h7
`define LINE_CMP0_MINUS      3'h0
`define LINE_CMP0_PLUS       3'h1
`define LINE_CMP0_OUT        3'h2
`define LINE_CMP1_OUT        3'h3
`define LINE_CMP1_MINUS      3'h4

// masks of lines taken over by an enabled comparator
`define MASK_CMP0_PULL       8'h07
`define MASK_CMP1_PULL       8'h18
`define MASK_CMP0_FORCE      8'h04
`define MASK_CMP1_FORCE      8'h08

`endif

// ---- design/io_ports_pkg.sv ----
// Purpose: types shared by the i/o port design files
// Assumes: nothing beyond the params header
// Notes:   state structs follow the one-struct-per-module style
package io_ports_pkg;

    // read-modify-write operations on a port location
    typedef enum logic [1:0] {
        bitop_set,
        bitop_clear,
        bitop_complement
    } bitop_e;

    // divided frequency output state
    typedef struct packed {
        logic level;
    } divider_state_s;

    // register file and read path state of the top
    typedef struct packed {
        logic [7:0] port_a_latch;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_latch;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_latch;
        logic [7:0] port_c_direction;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic [7:0] wake_ref;
        logic       wake_up;
    } port_state_s;

endpackage : io_ports_pkg

// ---- design/port_line_mux.sv ----
// Purpose: per-port read selection, pad drive and pull-high control
// Assumes: direction bit 1 means input, 0 means push-pull output
// Notes:   purely combinational; state lives in the top
`timescale 1ns/10ps
`include "io_ports_params.svh"

module port_line_mux (
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] pad_in,
    input  wire logic [7:0] force_input,
    input  wire logic [7:0] alt_out_sel,
    input  wire logic [7:0] alt_out,
    input  wire logic [7:0] alt_read_sel,
    input  wire logic [7:0] alt_read,
    input  wire logic [7:0] pull_opt,
    input  wire logic [7:0] pull_block,
    output logic      [7:0] read_value,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] pull_en
);

    logic [7:0] as_input;

    // a forced line behaves as input whatever its direction bit says
    assign as_input   = dir | force_input;
    // pad for inputs, latch for outputs; the latch path feeds bit ops
    assign read_value = (alt_read_sel & alt_read)
                      | (~alt_read_sel & as_input & pad_in)
                      | (~alt_read_sel & ~as_input & latch);
    // output lines drive the latch, or the alternate source when routed
    assign pad_out    = (alt_out_sel & alt_out) | (~alt_out_sel & latch);
    assign pad_oe     = ~as_input;
    // pull-high exists only where the option is chosen
    assign pull_en    = pull_opt & ~pull_block;

endmodule : port_line_mux

// ---- design/freq_divider.sv ----
// Purpose: divided frequency source toggled by a timer overflow
// Assumes: overflow inputs are one-cycle pulses on clk
// Notes:   output rate is half the chosen overflow rate
`timescale 1ns/10ps
`include "io_ports_params.svh"

module freq_divider
    import io_ports_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic overflow_zero,
    input  wire logic overflow_one,
    input  wire logic src_sel,
    output logic      level
);

    divider_state_s state;
    divider_state_s next_state;
    logic           tick;

    // only one timer can reach the divider at a time
    assign tick = src_sel ? overflow_one : overflow_zero;

    ////////////////////////////////////////////////////////////////////////
    // toggle per overflow: with preload n the overflow rate is
    // f_timer/(256-n), so the output is f_timer/(2*(256-n))
    always_comb begin
        next_state = state;
        if (tick) begin
            next_state.level = ~state.level;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule : freq_divider

// ---- design/io_ports_with_freq_divider_pin.sv ----
// Purpose: three 8-bit i/o ports with direction registers, shared
//          timer, comparator and divided frequency lines
// Assumes: one data memory access or bit op per cycle; pads are
//          synchronous to clk
// Notes:
// Contract
// - port latches sit at data memory 12h, 14h, 16h, read and write.
// - reads sample pads unlatched at the second phase strobe.
// - latch holds written data until rewritten, driven on output lines.
// - direction registers at 13h, 15h, 17h, one bit per line.
// - direction 1 is input, 0 is push-pull output.
// - read returns pad for input lines, latch for output lines.
// - after reset every line is undriven.
// - bit set, clear, complement read whole port, modify, write back; complement here inverts all 8 bits, not one.
// - every first port line can end power-down.
// - pull-high attached only when that line's option is chosen.
// - first port lines 3, 4, 7 carry freq out, timer inputs.
// - third port lines 0 to 4 are shared with the comparators.
// - freq option puts divided signal on line 3 output; input unchanged.
// - with freq option, latch bit 1 enables output, 0 forces low.
// - divided output toggles per overflow, half the overflow rate.
// - an option picks which timer feeds the divided output.
// - set and clear of first port bit 3 enable and disable output.
`timescale 1ns/10ps
`include "io_ports_params.svh"

module io_ports_with_freq_divider_pin
    import io_ports_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic       second_phase_clock,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    input  wire logic       bitop_en,
    input  wire bitop_e     bitop_kind,
    input  wire logic [2:0] bitop_bit,
    input  wire logic       bitop_dest_acc,
    input  wire logic [7:0] first_port_in,
    output logic      [7:0] first_port_out,
    output logic      [7:0] first_port_oe,
    output logic      [7:0] first_port_pull_en,
    input  wire logic [7:0] second_port_in,
    output logic      [7:0] second_port_out,
    output logic      [7:0] second_port_oe,
    output logic      [7:0] second_port_pull_en,
    input  wire logic [7:0] third_port_in,
    output logic      [7:0] third_port_out,
    output logic      [7:0] third_port_oe,
    output logic      [7:0] third_port_pull_en,
    input  wire logic [7:0] pull_high_opt_a,
    input  wire logic [7:0] pull_high_opt_b,
    input  wire logic [7:0] pull_high_opt_c,
    input  wire logic       freq_out_option,
    input  wire logic       freq_src_option,
    input  wire logic       timer_zero_overflow,
    input  wire logic       timer_one_overflow,
    output logic            divided_freq_out,
    output logic            timer_zero_ext_input,
    output logic            timer_one_ext_input,
    input  wire logic       cmp0_enable,
    input  wire logic       cmp1_enable,
    input  wire logic       comparator_zero_output,
    input  wire logic       comparator_one_output,
    output logic            comparator_zero_minus_input,
    output logic            comparator_zero_plus_input,
    output logic            comparator_one_minus_input,
    input  wire logic       power_down,
    output logic            wake_up
);

    port_state_s state;
    port_state_s next_state;
    logic [7:0]  read_a;
    logic [7:0]  read_b;
    logic [7:0]  read_c;
    logic [7:0]  force_c;
    logic [7:0]  pull_block_c;
    logic [7:0]  alt_read_c;
    logic [7:0]  alt_sel_c;
    logic [7:0]  freq_sel_a;
    logic [7:0]  freq_val_a;
    logic        divided;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // one-hot mask of a line index
    function automatic logic [7:0] line_mask(input logic [2:0] idx);
        line_mask = 8'h01 << idx;
    endfunction : line_mask

    // modify step of a read-modify-write
    function automatic logic [7:0] apply_bitop(input logic [7:0] value,
                                               input bitop_e     kind,
                                               input logic [2:0] idx);
        apply_bitop = value;
        case (kind)
            bitop_set:        apply_bitop = value | line_mask(idx);
            bitop_clear:      apply_bitop = value & ~line_mask(idx);
            bitop_complement: apply_bitop = ~value;
            default:          apply_bitop = value;
        endcase
    endfunction : apply_bitop

    ////////////////////////////////////////////////////////////////////////
    // shared line routing

    // divided signal reaches line 3 only with the option, gated by its
    // own latch bit so a clear parks the pin low
    assign freq_sel_a = freq_out_option ? line_mask(`LINE_FREQ_OUT) : 8'h00;
    assign freq_val_a = (state.port_a_latch[`LINE_FREQ_OUT] & divided)
                        ? line_mask(`LINE_FREQ_OUT) : 8'h00;

    // enabled comparators take their output lines as input only and
    // remove the pull-highs of their lines
    assign force_c      = (cmp0_enable ? `MASK_CMP0_FORCE : 8'h00)
                        | (cmp1_enable ? `MASK_CMP1_FORCE : 8'h00);
    assign pull_block_c = (cmp0_enable ? `MASK_CMP0_PULL : 8'h00)
                        | (cmp1_enable ? `MASK_CMP1_PULL : 8'h00);
    assign alt_sel_c    = force_c;
    assign alt_read_c   = ({8{comparator_zero_output}} & `MASK_CMP0_FORCE)
                        | ({8{comparator_one_output}} & `MASK_CMP1_FORCE);

    // timer and comparator inputs follow the pads directly
    assign timer_zero_ext_input        = first_port_in[`LINE_TIMER_ZERO];
    assign timer_one_ext_input         = first_port_in[`LINE_TIMER_ONE];
    assign comparator_zero_minus_input = third_port_in[`LINE_CMP0_MINUS];
    assign comparator_zero_plus_input  = third_port_in[`LINE_CMP0_PLUS];
    assign comparator_one_minus_input  = third_port_in[`LINE_CMP1_MINUS];

    ////////////////////////////////////////////////////////////////////////
    // per-port muxes
    port_line_mux first_mux (
        .latch        (state.port_a_latch),
        .dir          (state.port_a_direction),
        .pad_in       (first_port_in),
        .force_input  (8'h00),
        .alt_out_sel  (freq_sel_a),
        .alt_out      (freq_val_a),
        .alt_read_sel (8'h00),
        .alt_read     (8'h00),
        .pull_opt     (pull_high_opt_a),
        .pull_block   (8'h00),
        .read_value   (read_a),
        .pad_out      (first_port_out),
        .pad_oe       (first_port_oe),
        .pull_en      (first_port_pull_en)
    );

    port_line_mux second_mux (
        .latch        (state.port_b_latch),
        .dir          (state.port_b_direction),
        .pad_in       (second_port_in),
        .force_input  (8'h00),
        .alt_out_sel  (8'h00),
        .alt_out      (8'h00),
        .alt_read_sel (8'h00),
        .alt_read     (8'h00),
        .pull_opt     (pull_high_opt_b),
        .pull_block   (8'h00),
        .read_value   (read_b),
        .pad_out      (second_port_out),
        .pad_oe       (second_port_oe),
        .pull_en      (second_port_pull_en)
    );

    port_line_mux third_mux (
        .latch        (state.port_c_latch),
        .dir          (state.port_c_direction),
        .pad_in       (third_port_in),
        .force_input  (force_c),
        .alt_out_sel  (8'h00),
        .alt_out      (8'h00),
        .alt_read_sel (alt_sel_c),
        .alt_read     (alt_read_c),
        .pull_opt     (pull_high_opt_c),
        .pull_block   (pull_block_c),
        .read_value   (read_c),
        .pad_out      (third_port_out),
        .pad_oe       (third_port_oe),
        .pull_en      (third_port_pull_en)
    );

    freq_divider divider (
        .clk           (clk),
        .reset         (reset),
        .overflow_zero (timer_zero_overflow),
        .overflow_one  (timer_one_overflow),
        .src_sel       (freq_src_option),
        .level         (divided)
    );

    assign divided_freq_out = divided;

    ////////////////////////////////////////////////////////////////////////
    // register file, read path and wake detect
    always_comb begin
        logic [7:0] cur;
        logic [7:0] result;
        cur = `RST_NONE;
        result = `RST_NONE;
        next_state = state;
        next_state.rd_valid = 1'b0;
        // address decode of the current location, pad or latch per line
        if (addr == `OFS_PORT_A_LATCH) begin
            cur = read_a;
        end else if (addr == `OFS_PORT_A_DIRECTION) begin
            cur = state.port_a_direction;
        end else if (addr == `OFS_PORT_B_LATCH) begin
            cur = read_b;
        end else if (addr == `OFS_PORT_B_DIRECTION) begin
            cur = state.port_b_direction;
        end else if (addr == `OFS_PORT_C_LATCH) begin
            cur = read_c;
        end else if (addr == `OFS_PORT_C_DIRECTION) begin
            cur = state.port_c_direction;
        end else begin
            cur = `RST_NONE;
        end
        result = apply_bitop(cur, bitop_kind, bitop_bit);
        // no input latch: the pad is taken in the strobe cycle
        if (rd_en && second_phase_clock) begin
            next_state.rd_data  = cur;
            next_state.rd_valid = 1'b1;
        end
        // a plain write wins over a bit op issued in the same cycle
        if (wr_en || (bitop_en && !bitop_dest_acc)) begin
            if (wr_en) begin
                result = wr_data;
            end
            if (addr == `OFS_PORT_A_LATCH) begin
                next_state.port_a_latch = result;
            end else if (addr == `OFS_PORT_A_DIRECTION) begin
                next_state.port_a_direction = result;
            end else if (addr == `OFS_PORT_B_LATCH) begin
                next_state.port_b_latch = result;
            end else if (addr == `OFS_PORT_B_DIRECTION) begin
                next_state.port_b_direction = result;
            end else if (addr == `OFS_PORT_C_LATCH) begin
                next_state.port_c_latch = result;
            end else if (addr == `OFS_PORT_C_DIRECTION) begin
                next_state.port_c_direction = result;
            end
        end else if (bitop_en) begin
            // accumulator destination: result leaves on the read port
            next_state.rd_data  = result;
            next_state.rd_valid = 1'b1;
        end
        // any first port input change during power-down wakes
        next_state.wake_up = power_down
            && ((first_port_in ^ state.wake_ref) != 8'h00);
        if (!power_down) begin
            next_state.wake_ref = first_port_in;
        end
    end

    // reset leaves every direction bit at input
    always_ff @(posedge clk) begin
        if (reset) begin
            state                  <= '0;
            state.port_a_direction <= `RST_DIRECTION;
            state.port_b_direction <= `RST_DIRECTION;
            state.port_c_direction <= `RST_DIRECTION;
            state.port_a_latch     <= `RST_LATCH;
            state.port_b_latch     <= `RST_LATCH;
            state.port_c_latch     <= `RST_LATCH;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data  = state.rd_data;
    assign rd_valid = state.rd_valid;
    assign wake_up  = state.wake_up;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_read_port_a: assert property (
        rd_en && second_phase_clock && !bitop_en
        && addr == `OFS_PORT_A_LATCH
        |=> rd_valid && rd_data == $past(read_a))
        else $error("port read value wrong");
    a_latch_holds: assert property (
        !(wr_en || bitop_en) |=> $stable(state.port_a_latch))
        else $error("latch changed without write");
    a_dir_write: assert property (
        wr_en && addr == `OFS_PORT_C_DIRECTION
        |=> state.port_c_direction == $past(wr_data))
        else $error("direction write lost");
    a_output_drive: assert property (
        second_port_oe == ~state.port_b_direction
        && (second_port_out & second_port_oe)
           == (state.port_b_latch & second_port_oe))
        else $error("output drive mismatch");
    a_reset_undriven: assert property (
        $past(reset) |-> first_port_oe == 8'h00
        && second_port_oe == 8'h00 && third_port_oe == 8'h00)
        else $error("line driven after reset");
    a_bitop_rmw: assert property (
        bitop_en && !wr_en && !bitop_dest_acc
        && bitop_kind == bitop_set && addr == `OFS_PORT_A_LATCH
        |=> state.port_a_latch
            == ($past(read_a) | line_mask($past(bitop_bit))))
        else $error("bit set write back wrong");
    a_wake_pulse: assert property (
        power_down && $past(power_down) && !wake_up
        && $changed(first_port_in) |=> wake_up)
        else $error("no wake on port change");
    a_pull_option: assert property (
        first_port_pull_en == pull_high_opt_a)
        else $error("pull-high not per option");
    a_timer_route: assert property (
        timer_one_ext_input == first_port_in[`LINE_TIMER_ONE])
        else $error("timer input not routed");
    a_comparator_take: assert property (
        cmp0_enable |-> !third_port_oe[`LINE_CMP0_OUT]
        && third_port_pull_en[`LINE_CMP0_PLUS] == 1'b0)
        else $error("comparator line still driven");
    a_freq_gate: assert property (
        freq_out_option && !state.port_a_latch[`LINE_FREQ_OUT]
        |-> !first_port_out[`LINE_FREQ_OUT])
        else $error("freq line not forced low");
    a_freq_pass: assert property (
        freq_out_option && state.port_a_latch[`LINE_FREQ_OUT]
        |-> first_port_out[`LINE_FREQ_OUT] == divided)
        else $error("freq line not carrying divider");
    a_div_toggle: assert property (
        (freq_src_option ? timer_one_overflow : timer_zero_overflow)
        |=> divided != $past(divided))
        else $error("divider missed overflow");
    a_div_hold: assert property (
        !(freq_src_option ? timer_one_overflow : timer_zero_overflow)
        |=> $stable(divided))
        else $error("divider toggled from wrong timer");

    c_port_read: cover property (rd_en && second_phase_clock ##1 rd_valid);
    c_bitop_set: cover property (bitop_en && bitop_kind == bitop_set);
    c_freq_run: cover property (
        freq_out_option && first_port_out[`LINE_FREQ_OUT] ##1
        !first_port_out[`LINE_FREQ_OUT]);
    c_wake: cover property (wake_up);

endmodule : io_ports_with_freq_divider_pin

// ---- testbench/port_pad_model.sv ----
// Purpose: board side of one port: external drivers and pull-highs
// Assumes: ext_en marks the lines that the board drives
// Notes:   a released line without pull-high flips every cycle
`timescale 1ns/10ps

module port_pad_model (
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pad_in
);
    logic [7:0] prev = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // floating lines wander so a stale level never reads as good data;
    // the known start keeps an unknown from circulating forever
    always @(posedge clk) begin
        prev <= pad_in;
    end

    // device drive first, then board, then pull-high or float
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & (pull_en | ~prev));
endmodule : port_pad_model

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the three i/o ports
// Assumes: pull-high options mostly on; board drives input lines
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps

module tb_top;
    import io_ports_pkg::*;
    logic clk, reset, wr_en, rd_en, second_phase_clock, bitop_en;
    logic bitop_dest_acc, freq_out_option, freq_src_option, power_down;
    logic timer_zero_overflow, timer_one_overflow, cmp0_enable;
    logic cmp1_enable, comparator_zero_output, comparator_one_output;
    logic rd_valid, divided_freq_out, timer_zero_ext_input, wake_up;
    logic timer_one_ext_input, comparator_zero_minus_input;
    logic comparator_zero_plus_input, comparator_one_minus_input, lvl;
    logic [7:0] addr, wr_data, rd_data;
    logic [7:0] pin[3], pout[3], poe[3], pull[3], popt[3], ext[3], ext_en[3];
    logic [2:0] bitop_bit;
    bitop_e     bitop_kind;
    int         err_count, tests_run;

    io_ports_with_freq_divider_pin io_ports_with_freq_divider_pin_inst (.*,
        .first_port_in(pin[0]), .second_port_in(pin[1]),
        .third_port_in(pin[2]), .first_port_out(pout[0]),
        .second_port_out(pout[1]), .third_port_out(pout[2]),
        .first_port_oe(poe[0]), .second_port_oe(poe[1]),
        .third_port_oe(poe[2]), .first_port_pull_en(pull[0]),
        .second_port_pull_en(pull[1]), .third_port_pull_en(pull[2]),
        .pull_high_opt_a(popt[0]), .pull_high_opt_b(popt[1]),
        .pull_high_opt_c(popt[2]));
    for (genvar g = 0; g < 3; g++) begin : pads
        port_pad_model port_pad_model_inst (.clk(clk), .pad_out(pout[g]),
            .pad_oe(poe[g]), .pull_en(pull[g]), .ext_val(ext[g]),
            .ext_en(ext_en[g]), .pad_in(pin[g]));
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        step();
        wr_en = 1'b0;
        step();
    endtask : wr
    // a read without the phase strobe must be ignored
    task automatic rd(input logic [7:0] a, input logic ph,
                      input logic [7:0] e);
        addr = a;
        rd_en = 1'b1;
        second_phase_clock = ph;
        step();
        rd_en = 1'b0;
        second_phase_clock = 1'b0;
        check({7'h00, rd_valid}, {7'h00, ph});
        if (ph) check(rd_data, e);
        step();
    endtask : rd
    task automatic bop(input bitop_e k, input logic [2:0] b,
                       input logic [7:0] a, input logic acc,
                       input logic [7:0] e);
        bitop_kind = k;
        {bitop_bit, addr, bitop_dest_acc, bitop_en} = {b, a, acc, 1'b1};
        step();
        bitop_en = 1'b0;
        if (acc) check(rd_data, e);
        step();
    endtask : bop
    task automatic ovf(input logic src);
        {timer_one_overflow, timer_zero_overflow} = {src, ~src};
        step();
        {timer_one_overflow, timer_zero_overflow} = 2'b00;
        step();
    endtask : ovf
    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        {err_count, tests_run, addr, wr_data, bitop_bit, lvl} = '0;
        {wr_en, rd_en, second_phase_clock, bitop_en, bitop_dest_acc} = '0;
        {freq_out_option, freq_src_option, power_down, cmp0_enable} = '0;
        {timer_zero_overflow, timer_one_overflow, cmp1_enable} = '0;
        {comparator_zero_output, comparator_one_output} = '0;
        bitop_kind = bitop_set;
        popt = '{8'hff, 8'hff, 8'h5a};
        ext = '{8'h00, 8'h00, 8'h00};
        ext_en = '{8'hff, 8'hff, 8'hff};
        reset = 1'b1;
        repeat (5) step();
        reset = 1'b0;
        step();
        check(pull[2], 8'h5a);
        check(pull[1], 8'hff);
        rd(8'h12, 1'b0, 8'h00);
        rd(8'h18, 1'b1, 8'h00);
        // each port: low nibble input from board, high nibble driven
        for (int p = 0; p < 3; p++) begin
            check(poe[p], 8'h00);
            rd(8'h13 + 8'(2 * p), 1'b1, 8'hff);
            ext[p] = 8'h03;
            ext_en[p] = 8'h0f;
            wr(8'h12 + 8'(2 * p), 8'ha5);
            wr(8'h13 + 8'(2 * p), 8'h0f);
            check(poe[p], 8'hf0);
            check(pout[p] & 8'hf0, 8'ha0);
            rd(8'h12 + 8'(2 * p), 1'b1, 8'ha3);
        end
        // bit ops pick up the pad levels of input lines
        bop(bitop_set, 3'h6, 8'h14, 1'b0, 8'h00);
        check(pout[1], 8'he3);
        bop(bitop_clear, 3'h1, 8'h14, 1'b0, 8'h00);
        check(pout[1], 8'he1);
        bop(bitop_complement, 3'h0, 8'h14, 1'b1, 8'h1c);
        check(pout[1], 8'he1);
        wr(8'h17, 8'h00);
        cmp0_enable = 1'b1;
        step();
        check(poe[2], 8'hfb);
        check(pull[2], 8'h58);
        rd(8'h16, 1'b1, 8'ha1);
        // second comparator on top: line 3 reads its result
        cmp1_enable = 1'b1;
        comparator_one_output = 1'b1;
        step();
        check(poe[2], 8'hf3);
        check(pull[2], 8'h40);
        rd(8'h16, 1'b1, 8'ha9);
        check({7'h00, comparator_zero_minus_input}, 8'h01);
        check({7'h00, comparator_zero_plus_input}, 8'h00);
        check({7'h00, comparator_one_minus_input}, 8'h00);
        cmp0_enable = 1'b0;
        cmp1_enable = 1'b0;
        wr(8'h13, 8'hf7);
        wr(8'h12, 8'h08);
        freq_out_option = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ovf(1'b0);
            lvl = ~lvl;
            check({7'h00, divided_freq_out}, {7'h00, lvl});
            check(pout[0] & 8'h08, {4'h0, lvl, 3'h0});
        end
        ovf(1'b1);
        check({7'h00, divided_freq_out}, {7'h00, lvl});
        freq_src_option = 1'b1;
        ovf(1'b1);
        lvl = ~lvl;
        check({7'h00, divided_freq_out}, {7'h00, lvl});
        wr(8'h12, 8'h00);
        check(pout[0] & 8'h08, 8'h00);
        bop(bitop_set, 3'h3, 8'h12, 1'b0, 8'h00);
        check(pout[0] & 8'h08, 8'h08);
        ext[0] = 8'h10;
        ext_en[0] = 8'h90;
        step();
        check({7'h00, timer_zero_ext_input}, 8'h01);
        check({7'h00, timer_one_ext_input}, 8'h00);
        power_down = 1'b1;
        repeat (2) step();
        check({7'h00, wake_up}, 8'h00);
        ext[0] = 8'h00;
        for (int i = 0; i < 8 && wake_up !== 1'b1; i++) step();
        check({7'h00, wake_up}, 8'h01);
        finish_test();
    end
endmodule : tb_top
